//--- logic/gdc_params.svh
// constants of the gated decade counter
`ifndef GDC_PARAMS_SVH
`define GDC_PARAMS_SVH

`define GDC_DIGIT_W        4
`define GDC_DIGIT_ZERO     4'h0
`define GDC_DIGIT_LAST     4'h9
`define GDC_CARRY_SPLIT    4'h5
`define GDC_CARRY_RESET    1'b1
`define GDC_CLK_PERIOD_NS  10
`define GDC_RESET_ON_NS    100
`define GDC_RESET_ON_CYC   ((`GDC_RESET_ON_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_HOLD_W         4

`endif

//--- logic/gdc_pkg.sv
// types shared by the gated decade counter files
package gdc_pkg;
`include "gdc_params.svh"

  typedef struct packed {
    logic countClk;
    logic countInhibit;
    logic resetIn;
  } gdc_in_t;

  typedef struct packed {
    logic [`GDC_DIGIT_W-1:0] countDigitOutputs;
    logic                    carryTtl;
    logic                    carryEcl;
  } gdc_out_t;

endpackage

//--- logic/gdc_bcd_stage.sv
// one decade stage: counts 0..LAST and flags the wrap
`timescale 1ns/1ps
module gdc_bcd_stage #(
  parameter int            W    = 4,
  parameter logic [W-1:0]  LAST = 4'h9
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clear,
  input  wire logic         advance,
  output logic [W-1:0]      digit,
  output logic              wrap
);

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      digit <= '0;
    end else if (advance) begin
      digit <= (digit == LAST) ? '0 : W'(digit + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrap <= 1'b0;
    end else begin
      wrap <= advance && !clear && (digit == LAST);
    end
  end

endmodule

//--- logic/gdc_decade_counter.sv
// gated decade counter with bcd outputs and carry outputs
`timescale 1ns/1ps
`include "gdc_params.svh"

// Notes on behaviour
// R01 - divide by ten, counting bcd zero to nine on four parallel outputs
// R02 - reset input high holds count at zero, overriding clock and inhibit
// R03 - inhibit held high stops the count from advancing on clock edges
// R04 - clock rise with inhibit low, or inhibit rise with clock low, advances
// R05 - outside logic reads the digit only once clocking stopped or inhibited
// R06 - carry outputs make one cycle per ten edges, rising on the nine-to-zero wrap
module gdc_decade_counter #(
  parameter int RESET_ON_CYC = `GDC_RESET_ON_CYC
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire gdc_pkg::gdc_in_t  pinIn,
  output gdc_pkg::gdc_out_t      pinOut
);
  import gdc_pkg::*;

  localparam logic [`GDC_HOLD_W-1:0] HOLD_LOAD = `GDC_HOLD_W'(RESET_ON_CYC - 1);

  logic                    prevClk;
  logic                    prevInh;
  logic                    prevRst;
  logic [`GDC_HOLD_W-1:0]  holdCnt;
  logic                    clearCount;
  logic                    clkRise;
  logic                    inhRise;
  logic                    advance;
  logic [`GDC_DIGIT_W-1:0] digit;
  logic                    wrap;
  logic [7:0]              rstAge;

  // previous levels start high so a level present at release is no edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prevClk <= 1'b1;
      prevInh <= 1'b1;
      prevRst <= 1'b1;
    end else begin
      prevClk <= pinIn.countClk;
      prevInh <= pinIn.countInhibit;
      prevRst <= pinIn.resetIn;
    end
  end

  // R02 minimum reset time
  // a short reset pulse still clears for the full on-time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdCnt <= '0;
    end else if (pinIn.resetIn && !prevRst) begin
      holdCnt <= HOLD_LOAD;
    end else if (holdCnt != '0) begin
      holdCnt <= holdCnt - 1'b1;
    end
  end

  // cycles since the reset pin last rose, saturating; read only by the checks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstAge <= 8'hFF;
    end else if (pinIn.resetIn && !prevRst) begin
      rstAge <= 8'h01;
    end else if (rstAge != 8'hFF) begin
      rstAge <= rstAge + 8'h01;
    end
  end

  // R02 reset overrides inputs
  assign clearCount = pinIn.resetIn || (holdCnt != '0);

  // R03 inhibit gates clock
  assign clkRise = pinIn.countClk && !prevClk && !pinIn.countInhibit;
  // R04 inhibit edge clocks
  assign inhRise = pinIn.countInhibit && !prevInh && !pinIn.countClk;
  assign advance = (clkRise || inhRise) && !clearCount;

  // R01 decade count
  gdc_bcd_stage #(
    .W    (`GDC_DIGIT_W),
    .LAST (`GDC_DIGIT_LAST)
  ) u_stage (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (clearCount),
    .advance (advance),
    .digit   (digit),
    .wrap    (wrap)
  );

  // R01 parallel digit outputs
  // R05 digit lags one cycle; only valid once counting has paused
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut.countDigitOutputs <= `GDC_DIGIT_ZERO;
    end else begin
      pinOut.countDigitOutputs <= digit;
    end
  end

  // R06 carry square wave
  // high for 0..4, low for 5..9, so the rise marks the wrap for a next decade
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut.carryTtl <= `GDC_CARRY_RESET;
      pinOut.carryEcl <= `GDC_CARRY_RESET;
    end else begin
      pinOut.carryTtl <= (digit < `GDC_CARRY_SPLIT);
      pinOut.carryEcl <= (digit < `GDC_CARRY_SPLIT);
    end
  end

  // expected successor, read only by the checks below
  logic [`GDC_DIGIT_W-1:0] expNext;
  assign expNext = (digit == `GDC_DIGIT_LAST) ? `GDC_DIGIT_ZERO : `GDC_DIGIT_W'(digit + 1'b1);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // samplers start high, so a level present in the first cycle after release never counts as an edge
  sequence s_clk_edge;
    $rose(pinIn.countClk) && !$past(sys_rst) && !pinIn.countInhibit && !clearCount;
  endsequence

  sequence s_inh_edge;
    $rose(pinIn.countInhibit) && !$past(sys_rst) && !pinIn.countClk && !clearCount;
  endsequence

  sequence s_wrap_edge;
    advance && (digit == `GDC_DIGIT_LAST);
  endsequence

  sequence s_inh_held;
    pinIn.countInhibit && prevInh && !clearCount;
  endsequence

  property p_digit_range;
    digit <= `GDC_DIGIT_LAST;
  endproperty
  a_digit_range: assert property (p_digit_range) else $error("count left bcd range"); // R01

  property p_output_follows;
    ##1 pinOut.countDigitOutputs == $past(digit);
  endproperty
  a_output_follows: assert property (p_output_follows) else $error("digit outputs lag wrong"); // R01

  property p_reset_zero;
    pinIn.resetIn |-> ##1 (digit == `GDC_DIGIT_ZERO) ##1 (pinOut.countDigitOutputs == `GDC_DIGIT_ZERO);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not force zero"); // R02

  property p_reset_time;
    (rstAge <= 8'(RESET_ON_CYC)) |-> (digit == `GDC_DIGIT_ZERO);
  endproperty
  a_reset_time: assert property (p_reset_time) else $error("reset pulse cleared too briefly"); // R02

  property p_inhibit_blocks;
    pinIn.countInhibit && prevInh && !clearCount |=> $stable(digit);
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("count moved while inhibited"); // R03

  property p_clk_edge_counts;
    logic [`GDC_DIGIT_W-1:0] want;
    (s_clk_edge, want = expNext) |=> digit == want;
  endproperty
  a_clk_edge_counts: assert property (p_clk_edge_counts) else $error("clock edge not counted"); // R04

  property p_inh_edge_counts;
    logic [`GDC_DIGIT_W-1:0] want;
    (s_inh_edge, want = expNext) |=> digit == want;
  endproperty
  a_inh_edge_counts: assert property (p_inh_edge_counts) else $error("inhibit edge not counted"); // R04

  property p_no_spurious;
    !advance && !clearCount |=> $stable(digit);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("count moved without an edge"); // R04

  property p_carry_wrap;
    s_wrap_edge |-> ##1 wrap ##1 ($rose(pinOut.carryTtl) && pinOut.carryEcl);
  endproperty
  a_carry_wrap: assert property (p_carry_wrap) else $error("carry missed the wrap"); // R06

  property p_carry_fall;
    advance && (digit == 4'h4) |-> ##2 $fell(pinOut.carryTtl) && !pinOut.carryEcl;
  endproperty
  a_carry_fall: assert property (p_carry_fall) else $error("carry fell at wrong count"); // R06

  property p_out_zero_hold;
    (rstAge <= 8'(RESET_ON_CYC)) |-> ##1 (pinOut.countDigitOutputs == `GDC_DIGIT_ZERO);
  endproperty
  a_out_zero_hold: assert property (p_out_zero_hold) else $error("digit outputs left zero too soon"); // R02

  property p_clear_wins;
    clearCount |=> (digit == `GDC_DIGIT_ZERO) && !wrap;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("edge beat the reset"); // R02

  property p_reset_carry;
    pinIn.resetIn |-> ##2 (pinOut.carryTtl && pinOut.carryEcl);
  endproperty
  a_reset_carry: assert property (p_reset_carry) else $error("carry low after reset"); // R02

  property p_both_rise;
    $rose(pinIn.countClk) && $rose(pinIn.countInhibit) && !clearCount |=> $stable(digit);
  endproperty
  a_both_rise: assert property (p_both_rise) else $error("joint rise was counted"); // R04

  // outputs lag the count by one edge, so look two edges on
  property p_output_frozen;
    s_inh_held |-> ##2 $stable(pinOut.countDigitOutputs);
  endproperty
  a_output_frozen: assert property (p_output_frozen) else $error("digit outputs moved while inhibited"); // R03

  // nine goes to zero, so a second wrap needs ten more edges
  property p_wrap_single;
    wrap |=> !wrap;
  endproperty
  a_wrap_single: assert property (p_wrap_single) else $error("carry wrap flagged twice"); // R06

endmodule

//--- bench/gdc_source.sv
// signal source for the counter's clock, inhibit and reset pins
`timescale 1ns/1ps
module gdc_source (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire gdc_pkg::gdc_in_t reqPins,
  output gdc_pkg::gdc_in_t      pins
);
  import gdc_pkg::*;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins <= '0;
    end else begin
      pins <= reqPins;
    end
  end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the gated decade counter
`timescale 1ns/1ps
module tb_top;
  import gdc_pkg::*;
  localparam int RC = 2;
  logic        clk;
  logic        sys_rst;
  gdc_in_t     reqPins;
  gdc_in_t     pins;
  gdc_in_t     lastPins;
  gdc_out_t    pinOut;
  gdc_out_t    e;
  gdc_out_t    expQ[$];
  logic [3:0]  cnt;
  logic [31:0] lfsr;
  int          hold;
  int          cycles;
  int          fail_count;
  int          total_checks;

  gdc_source i_src (.clk(clk), .sys_rst(sys_rst), .reqPins(reqPins), .pins(pins));
  gdc_decade_counter #(.RESET_ON_CYC(RC)) i_dut (.clk(clk), .sys_rst(sys_rst), .pinIn(pins), .pinOut(pinOut));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic drive(input logic c, input logic i, input logic r, input int n);
    repeat (n) begin
      @(posedge clk);
      reqPins <= '{c, i, r};
    end
  endtask

  // model: samplers start high, so a level seen at release is no edge
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt = 4'h0;
      hold = 0;
      lastPins = '1;
      expQ.delete();
    end else begin
      if (pins.resetIn || hold > 0)
        cnt = 4'h0;
      else if ((pins.countClk && !lastPins.countClk && !pins.countInhibit)
               || (pins.countInhibit && !lastPins.countInhibit && !pins.countClk))
        cnt = (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
      hold = (pins.resetIn && !lastPins.resetIn) ? RC - 1 : (hold > 0 ? hold - 1 : 0);
      lastPins = pins;
      expQ.push_back('{cnt, cnt < 4'h5, cnt < 4'h5});
    end
  end

  // outputs trail the internal count by one edge
  always @(posedge clk) begin
    #1;
    if (!sys_rst && expQ.size() > 1) begin
      e = expQ.pop_front();
      total_checks++;
      if (pinOut !== e) begin
        fail_count++;
        $display("MISMATCH at %0t: got %h want %h", $time, pinOut, e);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("MISMATCH at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    sys_rst = 1'b1;
    reqPins = '0;
    cycles = 0;
    fail_count = 0;
    total_checks = 0;
    lfsr = 32'h4FAF;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 24; k++) drive(k[0], 1'b0, 1'b0, 1);
    for (int k = 0; k < 8; k++) drive(k[0], 1'b1, 1'b0, 1);
    for (int k = 0; k < 8; k++) drive(1'b0, k[0], 1'b0, 1);
    drive(1'b0, 1'b0, 1'b1, 1);
    drive(1'b1, 1'b0, 1'b1, 1);
    drive(1'b0, 1'b0, 1'b1, 2);
    drive(1'b0, 1'b0, 1'b0, RC + 2);
    repeat (400) begin
      lfsr = next_lfsr(lfsr);
      drive(lfsr[0], lfsr[5], 1'b0, 1);
    end
    drive(1'b0, 1'b1, 1'b0, 6);
    @(posedge clk);
    #1;
    total_checks++;
    if (pinOut.countDigitOutputs !== cnt) begin
      fail_count++;
      $display("MISMATCH at %0t: stopped digit %h want %h", $time, pinOut.countDigitOutputs, cnt);
    end
    summarize();
  end
endmodule
